/* File: adc_port_regs.svh */
`ifndef ADC_PORT_REGS_SVH
`define ADC_PORT_REGS_SVH

// ----------------------------------------------------------------
// frame and setup word layout
// ----------------------------------------------------------------
`define FRAME_BITS      5'd16
`define CFG_BITS        5'd12
`define CFG_LAST_EDGE   5'd11
`define CFG_W           12
`define CFG_WRITE_BIT   11
`define CFG_SEQ_HI_BIT  10
`define CFG_CH_HI_BIT   7
`define CFG_CH_LO_BIT   6
`define CFG_PM_HI_BIT   5
`define CFG_PM_LO_BIT   4
`define CFG_SEQ_LO_BIT  3
`define CFG_RANGE_BIT   1
`define CFG_CODING_BIT  0
`define CFG_KEEP_MASK   12'hcfb
`define CFG_RESET       12'h833

`endif

/* File: adc_port_pkg.sv */
`include "adc_port_regs.svh"

package adc_port_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_FRAME = 2'b10
  } port_state_t;

  typedef logic [`CFG_W-1:0] setup_word_t;

endpackage

/* File: adc_serial_control_word_port.sv */
`timescale 1ns/1ps
`include "adc_port_regs.svh"

// Contract
// - the device holds one 12-bit setup word that the host writes and can never read back.
// - each setup bit is sampled from the data input on a falling serial clock edge.
// - the setup word shifts in during the same clocks in which the prior result shifts out.
// - a word written in a frame governs the next conversion, not the one read in that frame.
// - only bits on the first 12 falling edges after select falls are loaded; later bits are ignored.
// - the word arrives most significant bit first, first bit to position eleven.
// - from the top the order is write flag, upper sequencer bit, two ignored bits, channel address.
// - then power mode, lower sequencer bit, one ignored bit, range select and coding select.
// - a write flag of 1 loads the following 11 bits; 0 discards them and keeps the stored word.
// - range select 0 picks the doubled-reference span, 1 the single span, from the next conversion.
// - coding select 0 gives twos complement, 1 straight binary, from the next conversion.
// - each output frame is two zeros, two channel bits, then 12 result bits msb first on falling edges.
module adc_serial_control_word_port
  import adc_port_pkg::*;
#(
  parameter int RESULT_W = 12
) (
  input  wire logic                core_clk_in,        // system clock, 25 MHz
  input  wire logic                reset_in,           // synchronous, active high
  input  wire logic                sclk_in,            // serial clock from host
  input  wire logic                cs_n_in,            // frame select, active low
  input  wire logic                din_in,             // serial setup data
  output logic                     dout_out,           // serial result data
  input  wire logic [RESULT_W-1:0] result_in,          // raw straight-binary result
  output logic                     conv_start_out,     // pulse: sample taken
  output logic [1:0]               channel_addr_out,   // channel of this conversion
  output logic [1:0]               power_mode_out,     // power mode of this conversion
  output logic [1:0]               sequencer_out,      // {hi, lo} sequencer bits
  output logic                     range_single_out,   // 1: single-reference span
  output logic                     coding_binary_out   // 1: straight binary coding
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  port_state_t       st_q, st_d;
  logic              sclk_q, sclk_d;
  logic [4:0]        cnt_q, cnt_d;
  logic [10:0]       in_q, in_d;
  setup_word_t       cfg_q, cfg_d;
  setup_word_t       act_q, act_d;
  logic [15:0]       shift_q, shift_d;
  logic              start_q, start_d;
  logic              fall;
  logic              start;
  setup_word_t       word12;

  assign fall   = sclk_q & ~sclk_in;
  assign start  = (st_q == ST_IDLE) & ~cs_n_in;
  assign word12 = {in_q, din_in};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    sclk_d  = sclk_in;
    cnt_d   = cnt_q;
    in_d    = in_q;
    cfg_d   = cfg_q;
    act_d   = act_q;
    shift_d = shift_q;
    start_d = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        if (!cs_n_in) begin
          st_d    = ST_FRAME;
          cnt_d   = 5'd0;
          start_d = 1'b1;
          // stored word only now becomes the live setup
          act_d   = cfg_q;
          shift_d = {2'b00, cfg_q[`CFG_CH_HI_BIT:`CFG_CH_LO_BIT],
                     result_in[RESULT_W-1] ^ ~cfg_q[`CFG_CODING_BIT],
                     result_in[RESULT_W-2:0]};
        end
      end
      ST_FRAME: begin
        if (cs_n_in) begin
          st_d    = ST_IDLE;
          // cleared so dout rests low between frames, even after a cut frame
          shift_d = 16'h0000;
        end else if (fall && cnt_q < `FRAME_BITS) begin
          cnt_d   = cnt_q + 5'd1;
          shift_d = {shift_q[14:0], 1'b0};
          if (cnt_q < `CFG_BITS) begin
            in_d = {in_q[9:0], din_in};
          end
          if (cnt_q == `CFG_LAST_EDGE && word12[`CFG_WRITE_BIT]) begin
            cfg_d = word12 & `CFG_KEEP_MASK;
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      st_q    <= ST_IDLE;
      sclk_q  <= 1'b1;
      cnt_q   <= 5'd0;
      in_q    <= 11'h000;
      cfg_q   <= `CFG_RESET;
      act_q   <= `CFG_RESET;
      shift_q <= 16'h0000;
      start_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      sclk_q  <= sclk_d;
      cnt_q   <= cnt_d;
      in_q    <= in_d;
      cfg_q   <= cfg_d;
      act_q   <= act_d;
      shift_q <= shift_d;
      start_q <= start_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // dout rests low outside a frame; no read path exists for cfg_q
  assign dout_out          = shift_q[15];
  assign conv_start_out    = start_q;
  assign channel_addr_out  = act_q[`CFG_CH_HI_BIT:`CFG_CH_LO_BIT];
  assign power_mode_out    = act_q[`CFG_PM_HI_BIT:`CFG_PM_LO_BIT];
  assign sequencer_out     = {act_q[`CFG_SEQ_HI_BIT], act_q[`CFG_SEQ_LO_BIT]};
  assign range_single_out  = act_q[`CFG_RANGE_BIT];
  assign coding_binary_out = act_q[`CFG_CODING_BIT];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_load;
    @(posedge core_clk_in) disable iff (reset_in)
    (st_q == ST_FRAME && !cs_n_in && fall && cnt_q == `CFG_LAST_EDGE && in_q[10])
      |=> cfg_q == ($past(word12) & `CFG_KEEP_MASK);
  endproperty
  a_load: assert property (p_load) else $error("setup word not loaded");

  property p_discard;
    @(posedge core_clk_in) disable iff (reset_in)
    (fall && cnt_q == `CFG_LAST_EDGE && !in_q[10]) |=> $stable(cfg_q);
  endproperty
  a_discard: assert property (p_discard) else $error("word loaded without write flag");

  property p_only12;
    @(posedge core_clk_in) disable iff (reset_in)
    !$stable(cfg_q) |-> $past(fall && cnt_q == `CFG_LAST_EDGE && st_q == ST_FRAME);
  endproperty
  a_only12: assert property (p_only12) else $error("setup changed off the 12th edge");

  property p_ignored;
    @(posedge core_clk_in) disable iff (reset_in)
    (cfg_q[9:8] == 2'b00) && !cfg_q[2];
  endproperty
  a_ignored: assert property (p_ignored) else $error("ignored bits stored");

  property p_next_conv;
    @(posedge core_clk_in) disable iff (reset_in)
    !$stable(act_q) |-> $past(start);
  endproperty
  a_next_conv: assert property (p_next_conv) else $error("live setup changed mid frame");

  property p_lead_zero;
    @(posedge core_clk_in) disable iff (reset_in)
    start |=> !dout_out && shift_q[14] == 1'b0;
  endproperty
  a_lead_zero: assert property (p_lead_zero) else $error("leading zeros missing");

  property p_shift;
    @(posedge core_clk_in) disable iff (reset_in)
    (st_q == ST_FRAME && !cs_n_in && fall && cnt_q < `FRAME_BITS)
      |=> shift_q[15] == $past(shift_q[14]);
  endproperty
  a_shift: assert property (p_shift) else $error("result not shifted on falling edge");

  property p_chan_code;
    @(posedge core_clk_in) disable iff (reset_in)
    start |=> shift_q[13:12] == $past(cfg_q[7:6])
              && shift_q[11] == ($past(result_in[RESULT_W-1]) ^ ~$past(cfg_q[0]));
  endproperty
  a_chan_code: assert property (p_chan_code) else $error("frame header or coding wrong");

  property p_idle_low;
    @(posedge core_clk_in) disable iff (reset_in)
    (st_q == ST_IDLE) |-> !dout_out;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("dout not low between frames");

  property p_start_pulse;
    @(posedge core_clk_in) disable iff (reset_in)
    start |=> conv_start_out && act_q == $past(cfg_q);
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("bad start setup");

  property p_late_bits;
    @(posedge core_clk_in) disable iff (reset_in)
    (st_q == ST_FRAME && fall && cnt_q >= `CFG_BITS) |=> $stable(in_q);
  endproperty
  a_late_bits: assert property (p_late_bits) else $error("late din bit captured");

  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  c_write:   cover property (@(posedge core_clk_in) disable iff (reset_in)
                             fall && cnt_q == `CFG_LAST_EDGE && in_q[10]);
  c_nowrite: cover property (@(posedge core_clk_in) disable iff (reset_in)
                             fall && cnt_q == `CFG_LAST_EDGE && !in_q[10]);
  c_full:    cover property (@(posedge core_clk_in) disable iff (reset_in)
                             st_q == ST_FRAME && cnt_q == `FRAME_BITS && cs_n_in);
  c_short:   cover property (@(posedge core_clk_in) disable iff (reset_in)
                             st_q == ST_FRAME && cs_n_in && cnt_q < `CFG_BITS);
  c_twos:    cover property (@(posedge core_clk_in) disable iff (reset_in)
                             start && !cfg_q[`CFG_CODING_BIT]);

endmodule

/* File: host_serial_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// host side of the serial setup port
// ----------------------------------------
module host_serial_model (
  input  wire logic clk_in,   // core clock
  output logic      sclk_out, // serial clock, idles high
  output logic      cs_n_out, // frame select
  output logic      din_out,  // setup data
  input  wire logic dout_in   // result data
);
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    din_out  = 1'b0;
  end
  // nbits below 16 cuts the frame short on purpose
  task automatic xfer(input logic [11:0] w, input int nbits, output logic [15:0] r);
    r = 16'h0000;
    cs_n_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    for (int i = 15; i >= 16 - nbits; i--) begin
      #1 r[i] = dout_in;
      @(posedge clk_in);
      sclk_out <= 1'b0;
      din_out  <= (i >= 4) ? w[i-4] : ~din_out;
      repeat (2) @(posedge clk_in);
      sclk_out <= 1'b1;
      @(posedge clk_in);
    end
    @(posedge clk_in);
    cs_n_out <= 1'b1;
    @(posedge clk_in);
  endtask
endmodule

/* File: adc_serial_control_word_port_test.sv */
`timescale 1ns/1ps
// ----------------------------------------
// frame level checks of the setup port
// ----------------------------------------
module adc_serial_control_word_port_test;
  import adc_port_pkg::*;
  logic        core_clk, reset, sclk, cs_n, din, dout, conv_start, range_single, coding_binary;
  logic [11:0] result;
  logic [1:0]  channel_addr, power_mode, sequencer;
  logic [15:0] rd;
  int          err_total, check_count, cycles, starts;
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  adc_serial_control_word_port i_dut (
    .core_clk_in(core_clk), .reset_in(reset), .sclk_in(sclk), .cs_n_in(cs_n),
    .din_in(din), .dout_out(dout), .result_in(result), .conv_start_out(conv_start),
    .channel_addr_out(channel_addr), .power_mode_out(power_mode),
    .sequencer_out(sequencer), .range_single_out(range_single),
    .coding_binary_out(coding_binary));
  host_serial_model i_host (
    .clk_in(core_clk), .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .dout_in(dout));
  task finish_test();
    if (err_total == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // hang guard, six frames need well under 500 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (conv_start === 1'b1) starts++;
    if (cycles == 2000) begin
      err_total++;
      finish_test();
    end
  end
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic [15:0] live(input logic [11:0] w);
    return {8'h00, w[10], w[3], w[7:6], w[5:4], w[1:0]};
  endfunction
  // live setup is that of the frame just run, checked after it ends
  task frame(input logic [11:0] w, input logic [11:0] res, input int nbits,
             input logic [15:0] exp_dout, input logic [11:0] exp_cfg);
    logic [15:0] m;
    m = 16'hffff << (16 - nbits);
    @(posedge core_clk);
    result <= res;
    i_host.xfer(w, nbits, rd);
    chk("dout", exp_dout & m, rd & m);
    chk("setup", live(exp_cfg),
        {8'h00, sequencer, channel_addr, power_mode, range_single, coding_binary});
  endtask
  initial begin
    reset = 1'b1;
    result = 12'h000;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1 chk("idle dout", 16'h0000, {15'h0000, dout});
    frame(12'hb9c, 12'h123, 16, 16'h0123, 12'h833);
    frame(12'h3ff, 12'h8a5, 16, 16'h20a5, 12'hb9c);
    frame(12'hc63, 12'h7ff, 16, 16'h2fff, 12'hb9c);
    frame(12'h800, 12'h000, 8, 16'h1000, 12'hc63);
    frame(12'h800, 12'h456, 16, 16'h1456, 12'hc63);
    frame(12'h000, 12'h001, 16, 16'h0801, 12'h800);
    chk("starts", 16'd6, 16'(starts));
    finish_test();
  end
endmodule
